/* verilog/rmc_pkg.sv */
// Constants and types shared by the radio misc config register bank.
// Assumes a single core clock at 50 MHz and byte-wide serial register access.
package rmc_pkg;

  // Register offsets, six-bit serial address space
  localparam logic [5:0] ADDR_PWR_CTRL  = 6'h2E;
  localparam logic [5:0] ADDR_CARRIER   = 6'h2F;
  localparam logic [5:0] ADDR_CLK_OVR   = 6'h32;
  localparam logic [5:0] ADDR_CLK_EN    = 6'h33;
  localparam logic [5:0] ADDR_LOCK_CNT  = 6'h38;
  localparam logic [5:0] ADDR_ID_BYTE0  = 6'h3C;
  localparam logic [5:0] ADDR_ID_BYTE1  = 6'h3D;
  localparam logic [5:0] ADDR_ID_BYTE2  = 6'h3E;
  localparam logic [5:0] ADDR_ID_BYTE3  = 6'h3F;

  // Reset values
  localparam logic [7:0] RST_PWR_CTRL   = 8'h00;
  localparam logic [7:0] RST_CARRIER    = 8'h00;
  localparam logic [7:0] RST_CLK_OVR    = 8'h00;
  localparam logic [7:0] RST_CLK_EN     = 8'h00;
  localparam logic [7:0] RST_LOCK_CNT   = 8'h64;

  // Field layout
  localparam int         CTRL_BIT       = 7;
  localparam logic [7:0] CTRL_MASK      = 8'h80;
  localparam int         CMD_WRITE_BIT  = 7;
  localparam int         CMD_BURST_BIT  = 6;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam int         ID_WIDTH       = 30;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // Lock delay timing
  localparam int         CLK_PERIOD_NS  = 20;
  localparam int         LOCK_STEP_NS   = 2000;
  localparam int         LOCK_STEP_CYC  = (LOCK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] LOCK_STEP_LAST = 7'(LOCK_STEP_CYC - 1);

  typedef enum logic [0:0] {
    RMC_ST_CMD  = 1'b0,
    RMC_ST_DATA = 1'b1
  } rmc_state_t;

  // Analog-control and control-register bits that steer this block
  typedef struct packed {
    logic cfg_write_en;
    logic id_read_en;
    logic auto_synth;
    logic pll_lock_used;
  } rmc_ctrl_t;

  typedef struct packed {
    rmc_state_t st;
    logic       sck_prev;
    logic [2:0] bit_cnt;
    logic       wr_dir;
    logic       burst;
    logic [5:0] addr;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic       miso;
    logic       miso_oe;
    logic [7:0] pwr_ctrl;
    logic [7:0] carrier;
    logic [7:0] clk_ovr;
    logic [7:0] clk_en;
    logic [7:0] lock_cnt;
    logic       lock_busy;
    logic [7:0] steps_left;
    logic [6:0] step_cyc;
    logic       lock_done;
  } rmc_regs_t;

endpackage : rmc_pkg

/* verilog/rmc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input; output changes only when stages two and three agree.
module rmc_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_b_in,
  input  wire logic ce_in,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q      <= RESET_VAL;
      s2_q      <= RESET_VAL;
      s3_q      <= RESET_VAL;
      level_out <= RESET_VAL;
    end else if (ce_in) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end

endmodule // rmc_pin_sync

/* verilog/rmc_regs.sv */
// Misc configuration and identification registers behind the serial port.
// Assumes the analog control and control registers live elsewhere and arrive as
// same-clock levels; serial pins are asynchronous and well below the core clock.
module rmc_regs (
  // Clock, reset, enable
  input  wire logic               core_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               ce_in,
  // Serial register port
  input  wire logic               spi_sck_in,
  input  wire logic               spi_ss_b_in,
  input  wire logic               spi_mosi_in,
  output logic                    spi_miso_out,
  output logic                    spi_miso_oe_out,
  // Steering bits from other registers
  input  wire rmc_pkg::rmc_ctrl_t ctrl_in,
  // Per-chip identification fuses
  input  wire logic [29:0]        chip_id_in,
  // Synthesizer lock timing
  input  wire logic               synth_start_in,
  output logic                    lock_done_out,
  output logic                    lock_busy_out,
  // Configuration outputs
  output logic                    power_save_out,
  output logic                    carrier_sense_override_out,
  output logic [7:0]              manual_clock_override_out,
  output logic [7:0]              manual_clock_gate_enable_out,
  output logic [7:0]              synth_lock_delay_count_out
);

  rmc_pkg::rmc_regs_t r_q;
  rmc_pkg::rmc_regs_t r_d;

  logic sck_s;
  logic ss_b_s;
  logic mosi_s;

  // Pins cross in through three stages; the filter costs about four cycles
  // of latency, so each serial clock phase must last longer than that
  rmc_pin_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .pin_in      (spi_sck_in),
    .level_out   (sck_s)
  );

  rmc_pin_sync #(.RESET_VAL(1'b1)) u_sync_ss (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .pin_in      (spi_ss_b_in),
    .level_out   (ss_b_s)
  );

  rmc_pin_sync #(.RESET_VAL(1'b0)) u_sync_mosi (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .pin_in      (spi_mosi_in),
    .level_out   (mosi_s)
  );

  // Read mux; the id is masked at the source so it never leaves ungated
  function automatic logic [7:0] read_byte(input rmc_pkg::rmc_regs_t s,
                                           input logic [5:0] a,
                                           input logic id_en,
                                           input logic [29:0] id);
    logic [31:0] idw;
    logic [7:0]  v;
    idw = {2'b00, (id_en ? id : 30'h0000_0000)};
    v   = rmc_pkg::ZERO_BYTE;
    case (a)
      rmc_pkg::ADDR_PWR_CTRL: v = s.pwr_ctrl;
      rmc_pkg::ADDR_CARRIER:  v = s.carrier;
      rmc_pkg::ADDR_CLK_OVR:  v = s.clk_ovr;
      rmc_pkg::ADDR_CLK_EN:   v = s.clk_en;
      rmc_pkg::ADDR_LOCK_CNT: v = s.lock_cnt;
      rmc_pkg::ADDR_ID_BYTE0: v = idw[7:0];
      rmc_pkg::ADDR_ID_BYTE1: v = idw[15:8];
      rmc_pkg::ADDR_ID_BYTE2: v = idw[23:16];
      rmc_pkg::ADDR_ID_BYTE3: v = idw[31:24];
      default:                v = rmc_pkg::ZERO_BYTE;
    endcase
    return v;
  endfunction

  always_comb begin
    logic       rise;
    logic       fall;
    logic [7:0] byte_in;
    logic [5:0] next_addr;
    rise      = 1'b0;
    fall      = 1'b0;
    byte_in   = rmc_pkg::ZERO_BYTE;
    next_addr = 6'h00;
    r_d       = r_q;
    r_d.lock_done = 1'b0;

    r_d.sck_prev = sck_s;
    rise    = sck_s & ~r_q.sck_prev;
    fall    = ~sck_s & r_q.sck_prev;
    byte_in = {r_q.shift_in[6:0], mosi_s};

    if (ss_b_s) begin
      // Deselect aborts any partial byte
      r_d.st        = rmc_pkg::RMC_ST_CMD;
      r_d.bit_cnt   = 3'h0;
      r_d.miso      = 1'b0;
      r_d.miso_oe   = 1'b0;
    end else begin
      r_d.miso_oe = 1'b1;
      if (fall) begin
        r_d.miso      = r_q.shift_out[7];
        r_d.shift_out = {r_q.shift_out[6:0], 1'b0};
      end
      if (rise) begin
        r_d.shift_in = byte_in;
        r_d.bit_cnt  = r_q.bit_cnt + 3'h1;
        if (r_q.bit_cnt == rmc_pkg::LAST_BIT) begin
          case (r_q.st)
            rmc_pkg::RMC_ST_CMD: begin
              r_d.wr_dir    = byte_in[rmc_pkg::CMD_WRITE_BIT];
              r_d.burst     = byte_in[rmc_pkg::CMD_BURST_BIT];
              r_d.addr      = byte_in[5:0];
              r_d.st        = rmc_pkg::RMC_ST_DATA;
              r_d.shift_out = read_byte(r_q, byte_in[5:0], ctrl_in.id_read_en, chip_id_in);
            end
            rmc_pkg::RMC_ST_DATA: begin
              if (r_q.wr_dir) begin
                case (r_q.addr)
                  // Reserved bits are stored as zero whatever the host sends
                  rmc_pkg::ADDR_PWR_CTRL: begin
                    if (ctrl_in.cfg_write_en) begin
                      r_d.pwr_ctrl = byte_in & rmc_pkg::CTRL_MASK;
                    end
                  end
                  rmc_pkg::ADDR_CARRIER: begin
                    if (ctrl_in.cfg_write_en) begin
                      r_d.carrier = byte_in & rmc_pkg::CTRL_MASK;
                    end
                  end
                  rmc_pkg::ADDR_CLK_OVR:  r_d.clk_ovr  = byte_in;
                  rmc_pkg::ADDR_CLK_EN:   r_d.clk_en   = byte_in;
                  rmc_pkg::ADDR_LOCK_CNT: r_d.lock_cnt = byte_in;
                  // Identification bytes and unmapped addresses drop the write
                  default:                r_d.addr     = r_q.addr;
                endcase
              end
              next_addr = r_q.burst ? r_q.addr + 6'h01 : r_q.addr;
              r_d.addr  = next_addr;
              // Preload follows the write so a burst reads fresh values
              r_d.shift_out = read_byte(r_d, next_addr, ctrl_in.id_read_en, chip_id_in);
            end
            default: r_d.st = rmc_pkg::RMC_ST_CMD;
          endcase
        end
      end
    end

    // Lock delay timer: steps of the 2 us unit, counted in core cycles
    // A start while busy is ignored; a restart is taken as early as the cycle that done shows
    if (r_q.lock_busy) begin
      if (r_q.steps_left == rmc_pkg::ZERO_BYTE) begin
        r_d.lock_busy = 1'b0;
        r_d.lock_done = 1'b1;
      end else if (r_q.step_cyc == rmc_pkg::LOCK_STEP_LAST) begin
        r_d.step_cyc   = 7'h00;
        r_d.steps_left = r_q.steps_left - 8'h01;
      end else begin
        r_d.step_cyc = r_q.step_cyc + 7'h01;
      end
    end else if (synth_start_in && ctrl_in.auto_synth && !ctrl_in.pll_lock_used) begin
      r_d.lock_busy  = 1'b1;
      r_d.steps_left = r_q.lock_cnt;
      r_d.step_cyc   = 7'h00;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_q            <= '0;
      r_q.st         <= rmc_pkg::RMC_ST_CMD;
      r_q.pwr_ctrl   <= rmc_pkg::RST_PWR_CTRL;
      r_q.carrier    <= rmc_pkg::RST_CARRIER;
      r_q.clk_ovr    <= rmc_pkg::RST_CLK_OVR;
      r_q.clk_en     <= rmc_pkg::RST_CLK_EN;
      r_q.lock_cnt   <= rmc_pkg::RST_LOCK_CNT;
    end else if (ce_in) begin
      r_q <= r_d;
    end
  end

  // Every output is a flop bit of the state record
  assign spi_miso_out                 = r_q.miso;
  assign spi_miso_oe_out              = r_q.miso_oe;
  assign lock_done_out                = r_q.lock_done;
  assign lock_busy_out                = r_q.lock_busy;
  assign power_save_out               = r_q.pwr_ctrl[rmc_pkg::CTRL_BIT];
  assign carrier_sense_override_out   = r_q.carrier[rmc_pkg::CTRL_BIT];
  assign manual_clock_override_out    = r_q.clk_ovr;
  assign manual_clock_gate_enable_out = r_q.clk_en;
  assign synth_lock_delay_count_out   = r_q.lock_cnt;

endmodule // rmc_regs

/* sim/rmc_regs_sva.sv */
// Port checks for the misc config register bank.
// Assumes ce_in stays high; bound into every rmc_regs instance.
module rmc_regs_chk (
  // Clock, reset, steering
  input wire logic               core_clk_in,
  input wire logic               rst_b_in,
  input wire logic               synth_start_in,
  input wire rmc_pkg::rmc_ctrl_t ctrl_in,
  // Observed outputs
  input wire logic               lock_done_out,
  input wire logic               lock_busy_out,
  input wire logic               power_save_out,
  input wire logic               carrier_sense_override_out,
  input wire logic [7:0]         synth_lock_delay_count_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Cycles since an accepted start, compared when done shows
  logic [15:0] cyc_q;
  logic        go;
  assign go = synth_start_in && !lock_busy_out && ctrl_in.auto_synth && !ctrl_in.pll_lock_used;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) cyc_q <= 16'h0000;
    else if (go) cyc_q <= 16'h0001;
    else if (lock_busy_out) cyc_q <= cyc_q + 16'h0001;
  end
  sequence s_go; go; endsequence
  sequence s_end; !lock_busy_out ##1 !lock_done_out; endsequence
  property p_rst_vals; $rose(rst_b_in) |-> synth_lock_delay_count_out == 8'h64
    && !power_save_out && !carrier_sense_override_out && !lock_busy_out; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad value after reset");
  property p_pwr_gate; $changed(power_save_out) |-> $past(ctrl_in.cfg_write_en); endproperty
  a_pwr_gate: assert property (p_pwr_gate) else $error("power bit moved while locked");
  property p_car_gate;
    $changed(carrier_sense_override_out) |-> $past(ctrl_in.cfg_write_en); endproperty
  a_car_gate: assert property (p_car_gate) else $error("override moved while locked");
  property p_keep; !ctrl_in.cfg_write_en [*2] |->
    $stable(power_save_out) && $stable(carrier_sense_override_out); endproperty
  a_keep: assert property (p_keep) else $error("locked value not kept");
  property p_lock_start; s_go |=> lock_busy_out; endproperty
  a_lock_start: assert property (p_lock_start) else $error("start not taken");
  property p_lock_refuse; !lock_busy_out && (!ctrl_in.auto_synth || ctrl_in.pll_lock_used)
    |=> !lock_busy_out; endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("start not refused");
  property p_lock_time;
    lock_done_out |-> cyc_q == 16'(synth_lock_delay_count_out) * 16'd100 + 16'd2; endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock delay length wrong");
  property p_done_pulse; lock_done_out |-> s_end; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");
  property p_busy_end; $fell(lock_busy_out) |-> lock_done_out; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
endmodule // rmc_regs_chk

bind rmc_regs rmc_regs_chk u_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .synth_start_in(synth_start_in),
  .ctrl_in(ctrl_in), .lock_done_out(lock_done_out), .lock_busy_out(lock_busy_out),
  .power_save_out(power_save_out), .carrier_sense_override_out(carrier_sense_override_out),
  .synth_lock_delay_count_out(synth_lock_delay_count_out));

/* sim/rmc_host_model.sv */
// Host controller model for the serial register port, mode 0, MSB first.
// Assumes pins may change just after a core clock edge.
module rmc_host_model (
  input  wire logic core_clk_in,
  input  wire logic spi_miso_in,
  output logic      spi_sck_out,
  output logic      spi_ss_b_out,
  output logic      spi_mosi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Eight cycles, above the five-cycle minimum half bit the port needs
  localparam int HALF = 8;
  initial begin
    spi_sck_out = 1'b0;
    spi_ss_b_out = 1'b1;
    spi_mosi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // Command then n bytes; data moves lowest byte first
  task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, input int n,
                      output logic [31:0] rd);
    rd = 32'h0000_0000;
    spi_ss_b_out = 1'b0;
    tick(HALF);
    for (int b = 0; b <= n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        spi_mosi_out = (b == 0) ? cmd[i] : wd[8*b-8+i];
        tick(HALF);
        spi_sck_out = 1'b1;
        if (b > 0) rd[8*b-8+i] = spi_miso_in;
        tick(HALF);
        spi_sck_out = 1'b0;
      end
    end
    tick(HALF);
    spi_ss_b_out = 1'b1;
    // Unselected data line must not look held
    spi_mosi_out = ~spi_mosi_out;
    tick(HALF);
  endtask
endmodule // rmc_host_model

/* sim/rmc_regs_tb_top.sv */
// Self-checking bench for the misc config register bank.
// Assumes the host model drives the serial pins; ce_in stays high.
module rmc_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk;
  logic               rst_b;
  logic               sck;
  logic               ss_b;
  logic               mosi;
  logic               miso;
  logic               oe;
  logic               start;
  logic               done;
  logic               busy;
  logic               pwr;
  logic               car;
  logic [7:0]         ovr;
  logic [7:0]         gen;
  logic [7:0]         cnt;
  logic [29:0]        id;
  logic [31:0]        rd;
  rmc_pkg::rmc_ctrl_t ctrl;
  int                 mismatches;
  int                 cmp_count;
  logic [5:0]         ra [6] = '{6'h2E, 6'h2F, 6'h32, 6'h33, 6'h38, 6'h10};
  logic [7:0]         rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'h00};
  rmc_regs uut (
    .core_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .spi_sck_in(sck), .spi_ss_b_in(ss_b),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe), .ctrl_in(ctrl),
    .chip_id_in(id), .synth_start_in(start), .lock_done_out(done), .lock_busy_out(busy),
    .power_save_out(pwr), .carrier_sense_override_out(car), .manual_clock_override_out(ovr),
    .manual_clock_gate_enable_out(gen), .synth_lock_delay_count_out(cnt));
  // Undriven data line toggles so a stale bit cannot pass
  rmc_host_model host (
    .core_clk_in(clk), .spi_miso_in(oe ? miso : clk), .spi_sck_out(sck),
    .spi_ss_b_out(ss_b), .spi_mosi_out(mosi));
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] nul;
    host.xfer({2'h2, a}, {24'h00_0000, d}, 1, nul);
  endtask
  task automatic reg_rd(input logic [5:0] a, input int n);
    host.xfer({1'b0, n > 1, a}, 32'h0000_0000, n, rd);
  endtask
  task automatic lock_run(input logic [7:0] n);
    int c;
    reg_wr(rmc_pkg::ADDR_LOCK_CNT, n);
    check("lock count", {24'h00_0000, n}, {24'h00_0000, cnt});
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    c = 0;
    while (done !== 1'b1 && c < 30000) begin
      @(posedge clk);
      #1;
      c++;
    end
    check("lock cycles", {24'h00_0000, n} * rmc_pkg::LOCK_STEP_CYC + 1, c);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1_000_000;
    mismatches++;
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    ctrl = '0;
    start = 1'b0;
    id = 30'h2A5C_3E17;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++) begin
      reg_rd(ra[i], 1);
      check("reset value", {24'h00_0000, rv[i]}, rd);
    end
    reg_wr(rmc_pkg::ADDR_PWR_CTRL, 8'h80);
    reg_wr(rmc_pkg::ADDR_CARRIER, 8'h80);
    check("locked writes", 32'h0000_0000, {30'h0000_0000, pwr, car});
    ctrl.cfg_write_en = 1'b1;
    reg_wr(rmc_pkg::ADDR_PWR_CTRL, 8'h80);
    reg_wr(rmc_pkg::ADDR_CARRIER, 8'h80);
    check("open writes", 32'h0000_0003, {30'h0000_0000, pwr, car});
    reg_rd(rmc_pkg::ADDR_CARRIER, 1);
    check("override", 32'h0000_0080, rd);
    ctrl.cfg_write_en = 1'b0;
    reg_wr(rmc_pkg::ADDR_PWR_CTRL, 8'h00);
    check("kept", 32'h0000_0001, {31'h0000_0000, pwr});
    reg_wr(rmc_pkg::ADDR_CLK_OVR, 8'h41);
    reg_wr(rmc_pkg::ADDR_CLK_EN, 8'h41);
    check("clock regs", 32'h0000_4141, {16'h0000, ovr, gen});
    reg_rd(rmc_pkg::ADDR_ID_BYTE0, 4);
    check("hidden id", 32'h0000_0000, rd);
    ctrl.id_read_en = 1'b1;
    reg_wr(rmc_pkg::ADDR_ID_BYTE0, 8'hFF);
    reg_rd(rmc_pkg::ADDR_ID_BYTE0, 4);
    check("id", {2'h0, id}, rd);
    reg_rd(rmc_pkg::ADDR_ID_BYTE3, 1);
    check("id top", {26'h000_0000, id[29:24]}, rd);
    ctrl.id_read_en = 1'b0;
    ctrl.auto_synth = 1'b1;
    lock_run(8'h02);
    lock_run(8'h00);
    ctrl.pll_lock_used = 1'b1;
    start = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("refused start", 32'h0000_0000, {31'h0000_0000, busy});
    start = 1'b0;
    close_out();
  end
endmodule // rmc_regs_tb_top
